// file: design/fdp_defines.svh
// Constants of the fast disk data-port engine.
`ifndef FDP_DEFINES_SVH
`define FDP_DEFINES_SVH
// ====================================================================
// Port map
`define FDP_BASE0     16'h01F0
`define FDP_BASE1     16'h0170
`define FDP_BASE2     16'h05F0
`define FDP_BASE3     16'h0570
`define FDP_ZERO_OFS  16'h0000
`define FDP_CTL_OFS   16'h0206
`define FDP_CMD_MASK  16'hFFF8
`define FDP_CTL_MASK  16'hFFFE
`define FDP_DATA_OFS  3'h0
`define FDP_SEL_OFS   3'h6
`define FDP_SEL_BIT   4
// ====================================================================
// Timing codes and limits
`define FDP_ASU_MAX   3'h4
`define FDP_REC_MAX   5'h18
`define FDP_WID_MAX   5'h10
`define FDP_REC_LIN   4'h8
`define FDP_REC_BASE  5'h0A
`define FDP_SPD_ISA   2'h3
`define FDP_SPD_B     2'h1
`define FDP_T2_END1   2'h0
`define FDP_T2_END2   2'h1
`define FDP_WID_LAST  5'h01
`define FDP_LEN_MAX   6'h3F
// ====================================================================
// Synchroniser bit positions
`define FDP_SY_ACT    0
`define FDP_SY_GNT    1
`define FDP_SY_IOR    2
`define FDP_SY_IOW    3
`define FDP_SY_RDY    4
`define FDP_SY_XA0    5
`define FDP_SY_XA1    6
`define FDP_SY_SBHE   7
`define FDP_SY_FB7    8
`define FDP_SY_XD_LO  9
`define FDP_SY_XD_HI  15
`endif

// file: design/fdp_pkg.sv
// Types of the fast disk data-port engine.
package fdp_pkg;
  typedef enum logic [2:0] {
    FDP_ST_IDLE = 3'h1,
    FDP_ST_WAIT = 3'h2,
    FDP_ST_CMD  = 3'h4
  } fdp_st_type;

  typedef struct packed {
    fdp_st_type  st;
    logic [1:0]  t2;
    logic [4:0]  wid;
    logic [2:0]  asu;
    logic [4:0]  rec;
    logic        second;
    logic        wr;
    logic        dword;
    logic [2:0]  drv;
    logic [3:0]  sel;
    logic [15:0] addr;
    logic        isa_drv;
    logic        isa_seen;
    logic [15:0] sy1;
    logic [15:0] sy2;
    logic        xa0;
    logic        xa1;
    logic        a2;
    logic        cs0_n;
    logic        cs1_n;
    logic        ior_n;
    logic        iow_n;
    logic        dir_lo;
    logic        dir_hi;
    logic        sys_data_buffer_enable_n_n;
    logic        iden_n;
    logic        done;
    logic        bypass;
    logic [7:0]  rbyte;
  } fdp_state_type;
endpackage

// file: design/fdp_timing_sel.sv
// Per-drive timing set selection and decoding of programmed codes.
`timescale 1ns/1ps
`include "fdp_defines.svh"
module fdp_timing_sel
  import fdp_pkg::*;
(
  // Drive and speed selection
  input  wire logic [2:0]  drv,
  input  wire logic [11:0] drive_speed,
  // Timing set A
  input  wire logic [3:0]  rd_a,
  input  wire logic [3:0]  wr_a,
  input  wire logic [3:0]  rec_a,
  input  wire logic [1:0]  asu_a,
  // Timing set B
  input  wire logic [3:0]  rd_b,
  input  wire logic [3:0]  wr_b,
  input  wire logic [3:0]  rec_b,
  input  wire logic [1:0]  asu_b,
  // Bypass flag and decoded clocks
  output logic             bypass,
  output logic [4:0]       rd_clk,
  output logic [4:0]       wr_clk,
  output logic [4:0]       rec_clk,
  output logic [2:0]       asu_clk
);
  // ==================================================================
  // Decoders
  function automatic logic [4:0] dec_width(input logic [3:0] c);
    dec_width = (c == 4'h0) ? `FDP_WID_MAX : {1'b0, c};
  endfunction

  function automatic logic [4:0] dec_rec(input logic [3:0] c);
    logic [4:0] lin;
    lin = {1'b0, c};
    if (c == 4'h0) begin
      dec_rec = `FDP_REC_MAX;
    end else if (c <= `FDP_REC_LIN) begin
      dec_rec = lin;
    end else begin
      dec_rec = `FDP_REC_BASE + 5'((lin - 5'h09) << 1);
    end
  endfunction

  // ==================================================================
  // Set selection
  logic [1:0] code;
  logic       use_b;

  always_comb begin
    if (drv[2]) begin
      code = {1'b0, drive_speed[8 + {30'h0, drv[1:0]}]};
    end else begin
      code = drive_speed[{drv[1:0], 1'b0} +: 2];
    end
    use_b   = (code == `FDP_SPD_B);
    bypass  = (code == `FDP_SPD_ISA);
    rd_clk  = dec_width(use_b ? rd_b : rd_a);
    wr_clk  = dec_width(use_b ? wr_b : wr_a);
    rec_clk = dec_rec(use_b ? rec_b : rec_a);
    asu_clk = (use_b ? asu_b : asu_a) == 2'h0 ? `FDP_ASU_MAX : {1'b0, (use_b ? asu_b : asu_a)};
  end
endmodule

// file: design/fdp_port.sv
// Fast disk data-port engine on the local bus clock.
`timescale 1ns/1ps
`include "fdp_defines.svh"
module fdp_port
  import fdp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Local bus I/O request
  input  wire logic        io_req,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_write,
  input  wire logic        io_dword,
  input  wire logic [7:0]  io_wdata,
  output logic             io_done,
  output logic             io_bypass,
  output logic [7:0]       io_rdata_3f7,
  // Configuration
  input  wire logic        cfg_late_t2,
  input  wire logic [11:0] cfg_drive_speed,
  input  wire logic [3:0]  cfg_rd_a,
  input  wire logic [3:0]  cfg_wr_a,
  input  wire logic [3:0]  cfg_rec_a,
  input  wire logic [1:0]  cfg_asu_a,
  input  wire logic [3:0]  cfg_rd_b,
  input  wire logic [3:0]  cfg_wr_b,
  input  wire logic [3:0]  cfg_rec_b,
  input  wire logic [1:0]  cfg_asu_b,
  // System pins
  input  wire logic        isa_cycle_active,
  input  wire logic        dma_bus_grant_n,
  input  wire logic        isa_ior_n,
  input  wire logic        isa_iow_n,
  input  wire logic        isa_xa0,
  input  wire logic        isa_xa1,
  input  wire logic        isa_sbhe_n,
  input  wire logic        drive_ready,
  input  wire logic        floppy_bit7_input,
  input  wire logic [6:0]  ext_data_bus,
  // Drive pins
  output logic             ext_addr_bit0,
  output logic             ext_addr_bit1,
  output logic             drive_addr_bit2,
  output logic             drive_cmd_select_n,
  output logic             drive_ctl_select_n,
  output logic             drive_read_strobe_n,
  output logic             drive_write_strobe_n,
  output logic             drive_buffer_enable_n,
  // Buffer steering
  output logic             sys_data_dir_lo,
  output logic             sys_data_dir_hi,
  output logic             sys_data_buffer_enable_n
);
  // ==================================================================
  // Port decoding
  localparam logic [15:0] BASES [4] = '{`FDP_BASE0, `FDP_BASE1, `FDP_BASE2, `FDP_BASE3};

  function automatic logic [2:0] port_chan(input logic [15:0] a, input logic [15:0] ofs,
                                           input logic [15:0] msk);
    port_chan = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if ((a & msk) == BASES[i] + ofs) begin
        port_chan = {1'b1, 2'(i)};
      end
    end
  endfunction

  // ==================================================================
  // State and decoded values
  fdp_state_type s;
  fdp_state_type n;
  logic [15:0]   pins;
  logic [2:0]    req_cmd;
  logic [2:0]    req_ctl;
  logic [2:0]    lat_cmd;
  logic [2:0]    lat_ctl;
  logic [2:0]    req_drv;
  logic [2:0]    t_drv;
  logic          t_bypass;
  logic [4:0]    rd_need;
  logic [4:0]    wr_need;
  logic [4:0]    rec_need;
  logic [2:0]    asu_need;
  logic          held;
  logic          t2_ok;
  logic          fast;
  logic          rd_act;
  logic          p3f7;

  assign pins    = {ext_data_bus, floppy_bit7_input, isa_sbhe_n, isa_xa1, isa_xa0, drive_ready,
                    isa_iow_n, isa_ior_n, dma_bus_grant_n, isa_cycle_active};
  assign req_cmd = port_chan(io_addr, `FDP_ZERO_OFS, `FDP_CMD_MASK);
  assign req_ctl = port_chan(io_addr, `FDP_CTL_OFS, `FDP_CTL_MASK);
  assign lat_cmd = port_chan(s.addr, `FDP_ZERO_OFS, `FDP_CMD_MASK);
  assign lat_ctl = port_chan(s.addr, `FDP_CTL_OFS, `FDP_CTL_MASK);
  assign req_drv = {req_cmd[1:0], s.sel[req_cmd[1:0]]};
  assign t_drv   = (s.st == FDP_ST_IDLE) ? req_drv : s.drv;

  // Timing set chosen per drive.
  fdp_timing_sel i_fdp_timing_sel (
    .drv         (t_drv),
    .drive_speed (cfg_drive_speed),
    .rd_a        (cfg_rd_a),
    .wr_a        (cfg_wr_a),
    .rec_a       (cfg_rec_a),
    .asu_a       (cfg_asu_a),
    .rd_b        (cfg_rd_b),
    .wr_b        (cfg_wr_b),
    .rec_b       (cfg_rec_b),
    .asu_b       (cfg_asu_b),
    .bypass      (t_bypass),
    .rd_clk      (rd_need),
    .wr_clk      (wr_need),
    .rec_clk     (rec_need),
    .asu_clk     (asu_need)
  );

  // ==================================================================
  // Next state
  always_comb begin
    n        = s;
    n.sy1    = pins;
    n.sy2    = s.sy1;
    n.done   = 1'b0;
    n.bypass = 1'b0;
    held     = !s.sy2[`FDP_SY_ACT] && s.sy2[`FDP_SY_GNT] && !s.isa_drv;
    t2_ok    = s.t2 >= (cfg_late_t2 ? `FDP_T2_END2 : `FDP_T2_END1);
    // Setup counter restarts whenever defaults are dropped.
    if (!held) begin
      n.asu = 3'h0;
    end else if (s.asu < `FDP_ASU_MAX) begin
      n.asu = s.asu + 3'h1;
    end
    // Recovery counter restarts on any active strobe.
    if (!s.ior_n || !s.iow_n) begin
      n.rec = 5'h00;
    end else if (s.rec < `FDP_REC_MAX) begin
      n.rec = s.rec + 5'h01;
    end
    // Tracks a bypassed drive-port cycle until the ISA cycle ends.
    if (s.isa_drv && s.sy2[`FDP_SY_ACT]) begin
      n.isa_seen = 1'b1;
    end
    if (s.isa_drv && s.isa_seen && !s.sy2[`FDP_SY_ACT]) begin
      n.isa_drv  = 1'b0;
      n.isa_seen = 1'b0;
    end
    case (s.st)
      FDP_ST_IDLE: begin
        if (io_req) begin
          n.addr   = io_addr;
          n.wr     = io_write;
          n.dword  = io_dword;
          n.second = 1'b0;
          // Data-port accesses run one 16-bit strobe, or two in a row when io_dword is set.
          if (req_cmd[2] && io_addr[2:0] == `FDP_DATA_OFS && !t_bypass) begin
            n.st  = FDP_ST_WAIT;
            n.t2  = 2'h0;
            n.drv = req_drv;
          end else begin
            n.bypass   = 1'b1;
            n.isa_drv  = req_cmd[2] || req_ctl[2];
            n.isa_seen = 1'b0;
            if (req_cmd[2] && io_write && io_addr[2:0] == `FDP_SEL_OFS) begin
              n.sel[req_cmd[1:0]] = io_wdata[`FDP_SEL_BIT];
            end
          end
        end
      end
      FDP_ST_WAIT: begin
        // Only fast data-port cycles wait on setup and recovery.
        if (t2_ok && s.asu >= asu_need && s.rec >= rec_need) begin
          n.st  = FDP_ST_CMD;
          n.wid = s.wr ? wr_need : rd_need;
        end else if (!t2_ok) begin
          n.t2 = s.t2 + 2'h1;
        end
      end
      FDP_ST_CMD: begin
        if (s.wid != `FDP_WID_LAST) begin
          n.wid = s.wid - 5'h01;
        end else if (s.sy2[`FDP_SY_RDY]) begin
          if (s.dword && !s.second) begin
            n.st     = FDP_ST_WAIT;
            n.second = 1'b1;
          end else begin
            n.st   = FDP_ST_IDLE;
            n.done = 1'b1;
          end
        end
      end
      default: begin
        n.st = FDP_ST_IDLE;
      end
    endcase
    // Strobes merge the fast engine with the copied ISA commands.
    fast    = (n.st == FDP_ST_CMD);
    n.ior_n = !((fast && !n.wr) || (n.isa_drv && !s.sy2[`FDP_SY_IOR]));
    n.iow_n = !((fast && n.wr) || (n.isa_drv && !s.sy2[`FDP_SY_IOW]));
    n.iden_n = n.ior_n && n.iow_n;
    // Address lines sit at the data-port defaults when idle.
    n.xa0   = held ? 1'b0 : s.sy2[`FDP_SY_XA0];
    n.xa1   = held ? 1'b0 : s.sy2[`FDP_SY_XA1];
    n.a2    = held ? 1'b0 : s.sy2[`FDP_SY_SBHE];
    n.cs0_n = held ? 1'b0 : !(s.isa_drv && lat_cmd[2]);
    n.cs1_n = held ? 1'b1 : !(s.isa_drv && lat_ctl[2]);
    // Reads from drive ports are driven by the disk buffers.
    rd_act   = !s.sy2[`FDP_SY_IOR];
    n.dir_lo = !(rd_act && !s.isa_drv);
    n.dir_hi = !(rd_act && !s.isa_drv);
    p3f7     = s.isa_drv && lat_ctl[2] && s.addr[0];
    n.sys_data_buffer_enable_n_n = p3f7 && !s.wr;
    if (p3f7 && !s.wr && rd_act) begin
      n.rbyte = {s.sy2[`FDP_SY_FB7], s.sy2[`FDP_SY_XD_HI:`FDP_SY_XD_LO]};
    end
  end

  // ==================================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s        <= '0;
      s.st     <= FDP_ST_IDLE;
      s.cs1_n  <= 1'b1;
      s.ior_n  <= 1'b1;
      s.iow_n  <= 1'b1;
      s.iden_n <= 1'b1;
      s.dir_lo <= 1'b1;
      s.dir_hi <= 1'b1;
      // Synchronisers start at the idle pin levels, so no false cycle follows reset.
      s.sy1[`FDP_SY_GNT] <= 1'b1;
      s.sy1[`FDP_SY_IOR] <= 1'b1;
      s.sy1[`FDP_SY_IOW] <= 1'b1;
      s.sy1[`FDP_SY_RDY] <= 1'b1;
      s.sy2[`FDP_SY_GNT] <= 1'b1;
      s.sy2[`FDP_SY_IOR] <= 1'b1;
      s.sy2[`FDP_SY_IOW] <= 1'b1;
      s.sy2[`FDP_SY_RDY] <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign io_done                  = s.done;
  assign io_bypass                = s.bypass;
  assign io_rdata_3f7             = s.rbyte;
  assign ext_addr_bit0            = s.xa0;
  assign ext_addr_bit1            = s.xa1;
  assign drive_addr_bit2          = s.a2;
  assign drive_cmd_select_n       = s.cs0_n;
  assign drive_ctl_select_n       = s.cs1_n;
  assign drive_read_strobe_n      = s.ior_n;
  assign drive_write_strobe_n     = s.iow_n;
  assign drive_buffer_enable_n    = s.iden_n;
  assign sys_data_dir_lo          = s.dir_lo;
  assign sys_data_dir_hi          = s.dir_hi;
  assign sys_data_buffer_enable_n = s.sys_data_buffer_enable_n_n;

  // ==================================================================
  // Checks
  logic [5:0] cmd_len;

  always_ff @(posedge sys_clk) begin
    if (srst || s.st != FDP_ST_CMD) begin
      cmd_len <= 6'h00;
    end else if (cmd_len != `FDP_LEN_MAX) begin
      cmd_len <= cmd_len + 6'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_cmd_start;
    s.st == FDP_ST_WAIT ##1 s.st == FDP_ST_CMD;
  endsequence

  sequence s_first_end;
    s.st == FDP_ST_CMD && s.dword && !s.second && s.wid == `FDP_WID_LAST && s.sy2[`FDP_SY_RDY];
  endsequence

  property p_rec_gate;
    s_cmd_start |-> $past(s.rec) >= $past(rec_need);
  endproperty
  a_rec_gate: assert property (p_rec_gate) else $error("command before recovery");

  property p_asu_gate;
    s_cmd_start |-> $past(s.asu) >= $past(asu_need);
  endproperty
  a_asu_gate: assert property (p_asu_gate) else $error("command before address setup");

  property p_t2_gate;
    s_cmd_start |-> $past(s.t2) >= (cfg_late_t2 ? `FDP_T2_END2 : `FDP_T2_END1);
  endproperty
  a_t2_gate: assert property (p_t2_gate) else $error("command before earliest start");

  property p_width;
    (s.st == FDP_ST_CMD && n.st != FDP_ST_CMD) |-> cmd_len + 6'h01 >= {1'b0, s.wr ? wr_need : rd_need};
  endproperty
  a_width: assert property (p_width) else $error("strobe shorter than programmed");

  property p_ready;
    (s.st == FDP_ST_CMD && s.wid == `FDP_WID_LAST && !s.sy2[`FDP_SY_RDY]) |=>
      !drive_read_strobe_n || !drive_write_strobe_n;
  endproperty
  a_ready: assert property (p_ready) else $error("command ended while not ready");

  property p_rec_clear;
    (!drive_read_strobe_n || !drive_write_strobe_n) |=> s.rec == 5'h00;
  endproperty
  a_rec_clear: assert property (p_rec_clear) else $error("recovery not cleared");

  property p_dword;
    s_first_end |=> (s.st == FDP_ST_WAIT && drive_read_strobe_n && drive_write_strobe_n) ##1 s.st == FDP_ST_WAIT;
  endproperty
  a_dword: assert property (p_dword) else $error("no recovery between halves");

  property p_default;
    (!s.sy2[`FDP_SY_ACT] && s.sy2[`FDP_SY_GNT] && !s.isa_drv) |=>
      !drive_cmd_select_n && drive_ctl_select_n && !ext_addr_bit0 && !ext_addr_bit1 && !drive_addr_bit2;
  endproperty
  a_default: assert property (p_default) else $error("defaults not driven");

  property p_fast_dir;
    (s.st == FDP_ST_CMD) |-> sys_data_dir_lo && sys_data_dir_hi;
  endproperty
  a_fast_dir: assert property (p_fast_dir) else $error("direction low in fast read");
endmodule

// file: test/fdp_drive_model.sv
// Behavioural model of the disk drives on the far side of the engine.
`timescale 1ns/1ps
module fdp_drive_model
  import fdp_pkg::*;
#(
  parameter logic [6:0] READ_DATA = 7'h2A,
  parameter int         HOLD_LOW  = 12
)
(
  // Clock
  input  wire logic       sys_clk,
  // Drive pins
  input  wire logic       drive_read_strobe_n,
  input  wire logic       drive_write_strobe_n,
  input  wire logic       drive_cmd_select_n,
  input  wire logic       drive_ctl_select_n,
  output logic            drive_ready,
  output logic [6:0]      ext_data_bus,
  // Scenario control
  input  wire logic       slow
);
  int   busy    = 0;
  int   hold    = 0;
  logic was_low = 1'b0;

  initial begin
    drive_ready = 1'b1;
    ext_data_bus = ~READ_DATA;
  end

  // ====================================================================
  // Ready and read data
  // A slow drive pulls ready low when a strobe starts; released data holds 4 cycles, then flips every cycle.
  always @(posedge sys_clk) begin
    if (!(drive_read_strobe_n && drive_write_strobe_n) && !was_low && slow) begin
      busy = HOLD_LOW;
    end else if (busy > 0) begin
      busy--;
    end
    was_low = !(drive_read_strobe_n && drive_write_strobe_n);
    drive_ready <= (busy == 0);
    if (!drive_read_strobe_n && !(drive_cmd_select_n && drive_ctl_select_n)) begin
      ext_data_bus <= READ_DATA;
      hold = 4;
    end else if (hold > 0) begin
      hold--;
    end else begin
      ext_data_bus <= ~ext_data_bus;
    end
  end
endmodule

// file: test/tb_fast_disk_port_timing.sv
// Self-checking testbench of the fast disk data-port engine.
`timescale 1ns/1ps
module tb_fast_disk_port_timing
  import fdp_pkg::*;
;
  logic        sys_clk, srst, io_req, io_write, io_dword, io_done, io_bypass, cfg_late_t2, slow;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata_3f7;
  logic [11:0] cfg_drive_speed;
  logic [3:0]  cfg_rd_a, cfg_wr_a, cfg_rec_a, cfg_rd_b, cfg_wr_b, cfg_rec_b;
  logic [1:0]  cfg_asu_a, cfg_asu_b;
  logic        isa_cycle_active, dma_bus_grant_n, isa_ior_n, isa_iow_n, isa_xa0, isa_xa1, isa_sbhe_n;
  logic        drive_ready, floppy_bit7_input;
  logic [6:0]  ext_data_bus;
  logic        ext_addr_bit0, ext_addr_bit1, drive_addr_bit2, drive_cmd_select_n, drive_ctl_select_n;
  logic        drive_read_strobe_n, drive_write_strobe_n, drive_buffer_enable_n;
  logic        sys_data_dir_lo, sys_data_dir_hi, sys_data_buffer_enable_n;
  logic        dir_all_hi, sys_data_buffer_enable_n_hi_any, en_low_any, rd_low_any, wr_low_any;
  int          failures, comparisons, cyc, lo_cnt, last_w, pulses, hi_cnt, last_gap;
  int          fall_cyc, req_cyc, kind, lat_early, lat1, p0;

  fdp_port i_fdp_port (.sys_clk, .srst, .io_req, .io_addr, .io_write, .io_dword, .io_wdata, .io_done,
    .io_bypass, .io_rdata_3f7, .cfg_late_t2, .cfg_drive_speed, .cfg_rd_a, .cfg_wr_a, .cfg_rec_a,
    .cfg_asu_a, .cfg_rd_b, .cfg_wr_b, .cfg_rec_b, .cfg_asu_b, .isa_cycle_active, .dma_bus_grant_n,
    .isa_ior_n, .isa_iow_n, .isa_xa0, .isa_xa1, .isa_sbhe_n, .drive_ready, .floppy_bit7_input,
    .ext_data_bus, .ext_addr_bit0, .ext_addr_bit1, .drive_addr_bit2, .drive_cmd_select_n,
    .drive_ctl_select_n, .drive_read_strobe_n, .drive_write_strobe_n, .drive_buffer_enable_n,
    .sys_data_dir_lo, .sys_data_dir_hi, .sys_data_buffer_enable_n);

  fdp_drive_model i_fdp_drive_model (.sys_clk, .drive_read_strobe_n, .drive_write_strobe_n,
    .drive_cmd_select_n, .drive_ctl_select_n, .drive_ready, .ext_data_bus, .slow);

  // ====================================================================
  // Clock and strobe monitor
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (!drive_read_strobe_n || !drive_write_strobe_n) begin
      if (lo_cnt == 0) begin
        pulses++;
        last_gap = hi_cnt;
        fall_cyc = cyc;
      end
      lo_cnt++;
      hi_cnt = 0;
    end else begin
      if (lo_cnt != 0) last_w = lo_cnt;
      lo_cnt = 0;
      hi_cnt++;
    end
    cyc++;
  end

  // ====================================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Runs the ISA cycle that the ordinary engine would run, watching the steering pins.
  task automatic isa_cycle(input logic w);
    dir_all_hi = 1'b1;
    {sys_data_buffer_enable_n_hi_any, en_low_any, rd_low_any, wr_low_any} = 4'h0;
    isa_cycle_active = 1'b1;
    tick(1);
    if (w) isa_iow_n = 1'b0;
    else isa_ior_n = 1'b0;
    repeat (8) begin
      tick(1);
      dir_all_hi &= sys_data_dir_lo & sys_data_dir_hi;
      sys_data_buffer_enable_n_hi_any |= sys_data_buffer_enable_n;
      en_low_any |= ~drive_buffer_enable_n;
      rd_low_any |= ~drive_read_strobe_n;
      wr_low_any |= ~drive_write_strobe_n;
    end
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
    tick(1);
    isa_cycle_active = 1'b0;
    tick(8);
  endtask

  task automatic access(input logic [15:0] a, input logic w, input logic dw, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    {io_req, io_addr, io_write, io_dword, io_wdata} = {1'b1, a, w, dw, d};
    tick(1);
    req_cyc = cyc;
    io_req = 1'b0;
    kind = 0;
    repeat (400) begin
      if (io_done === 1'b1) kind = 1;
      if (io_bypass === 1'b1) kind = 2;
      if (kind != 0) break;
      tick(1);
    end
    tick(2);
    if (kind == 2) isa_cycle(w);
  endtask

  task automatic select_drive(input logic [15:0] port, input logic odd);
    access(port, 1'b1, 1'b0, {3'h0, odd, 4'h0});
    check("select kind", kind, 2);
    tick(40);
  endtask

  // ====================================================================
  // Scenarios
  task automatic t_defaults;
    check("defaults", {ext_addr_bit0, ext_addr_bit1, drive_addr_bit2, drive_cmd_select_n, drive_ctl_select_n}, 5'h01);
    check("reset idle", {drive_read_strobe_n, drive_write_strobe_n, drive_buffer_enable_n, io_done, io_bypass}, 5'h1C);
    dma_bus_grant_n = 1'b0;
    isa_xa0 = 1'b1;
    tick(6);
    check("master addr", {ext_addr_bit0, drive_addr_bit2, drive_cmd_select_n, drive_ctl_select_n}, 4'hF);
    dma_bus_grant_n = 1'b1;
    isa_xa0 = 1'b0;
    tick(6);
    check("idle addr", ext_addr_bit0, 1'b0);
  endtask

  task automatic t_set_a;
    select_drive(16'h01F6, 1'b0);
    access(16'h01F0, 1'b0, 1'b0, 8'h00);
    check("fast read kind", kind, 1);
    check("read width a", last_w, 2);
    lat_early = fall_cyc - req_cyc;
    cfg_late_t2 = 1'b1;
    tick(40);
    access(16'h01F0, 1'b0, 1'b0, 8'h00);
    check("late start", fall_cyc - req_cyc, lat_early + 1);
    cfg_late_t2 = 1'b0;
    tick(40);
    access(16'h01F0, 1'b1, 1'b0, 8'h55);
    check("write width a", last_w, 3);
    tick(40);
    p0 = pulses;
    access(16'h01F0, 1'b0, 1'b1, 8'h00);
    check("dword kind", kind, 1);
    check("dword strobes", pulses - p0, 2);
    check("dword gap", last_gap >= 10, 1'b1);
  endtask

  task automatic t_set_b;
    select_drive(16'h01F6, 1'b1);
    access(16'h01F0, 1'b0, 1'b0, 8'h00);
    check("read width b", last_w, 8);
    lat1 = fall_cyc - req_cyc;
    check("held defaults", lat1, lat_early);
    tick(40);
    access(16'h01F0, 1'b1, 1'b0, 8'h00);
    check("write width b", last_w, 16);
    tick(20);
    isa_cycle_active = 1'b1;
    tick(4);
    isa_cycle_active = 1'b0;
    access(16'h01F0, 1'b0, 1'b0, 8'h00);
    check("setup after isa", (fall_cyc - req_cyc) > lat1, 1'b1);
    slow = 1'b1;
    tick(40);
    access(16'h01F0, 1'b0, 1'b0, 8'h00);
    check("ready stretch", last_w >= 12, 1'b1);
    slow = 1'b0;
  endtask

  task automatic t_bypass;
    select_drive(16'h0176, 1'b0);
    p0 = pulses;
    access(16'h0170, 1'b0, 1'b0, 8'h00);
    check("bypass kind", kind, 2);
    check("bypass strobes", pulses - p0, 1);
    access(16'h01F7, 1'b0, 1'b0, 8'h00);
    check("cmd read dir", dir_all_hi, 1'b1);
    check("cmd read copy", rd_low_any, 1'b1);
    access(16'h0060, 1'b0, 1'b0, 8'h00);
    check("isa read dir", dir_all_hi, 1'b0);
    check("isa read no copy", rd_low_any, 1'b0);
  endtask

  task automatic t_3f7;
    for (int b = 0; b < 2; b++) begin
      floppy_bit7_input = b[0];
      access(16'h03F7, 1'b0, 1'b0, 8'h00);
      check("3f7 byte", io_rdata_3f7, {b[0], 7'h2A});
      check("3f7 buffers off", sys_data_buffer_enable_n_hi_any, 1'b1);
      check("ctl read dir", dir_all_hi, 1'b1);
    end
    access(16'h03F7, 1'b1, 1'b0, 8'h0C);
    check("3f7 write sys buf", sys_data_buffer_enable_n_hi_any, 1'b0);
    check("3f7 write drive buf", en_low_any, 1'b1);
    check("ctl write copy", wr_low_any, 1'b1);
  endtask

  // ====================================================================
  // Main sequence and watchdog
  initial begin
    {srst, slow, floppy_bit7_input, dma_bus_grant_n, isa_ior_n, isa_iow_n, isa_sbhe_n} = 7'h7F;
    {io_req, io_addr, io_write, io_dword, io_wdata, cfg_late_t2} = 28'h0000000;
    {isa_cycle_active, isa_xa0, isa_xa1} = 3'h0;
    slow = 1'b0;
    cfg_drive_speed = 12'h134;
    {cfg_rd_a, cfg_wr_a, cfg_rec_a, cfg_asu_a} = 14'h08E5;
    {cfg_rd_b, cfg_wr_b, cfg_rec_b, cfg_asu_b} = 14'h2010;
    tick(3);
    srst = 1'b0;
    tick(2);
    t_defaults;
    t_set_a;
    t_set_b;
    t_bypass;
    t_3f7;
    final_report;
  end

  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    final_report;
  end
endmodule
